// file: logic/gfm_pkg.sv
// constants and codes for the multi-function pin mapper
// Summary of operation
// - the reset function survives a device reset only when it comes from nonvolatile memory.
// - code 0000 sends the device to deep sleep on a falling edge and wakes it on a rising edge.
// - code 0100 powers down the selected voltage outputs on a falling edge and powers them up on a rising edge.
// - code 1000 issues load-converter on the selected synchronous channels on a falling edge only.
// - code 1011 resets the device on a low pulse; a rising edge alone does nothing.
// - code 1101 unblocks register-map writes on a falling edge.
// - code 1101 blocks register-map writes on a rising edge, except the unlock field and the two-wire reset field.
// - the enable bits choose input or output, and per-channel functions follow the channel select.
// - after boot the pin level is sampled once and acted on; afterwards only edges act.
// - while the pin owns a function its software trigger is disabled.
// - after reset the pin is mapped to nothing until configured.
package gfm_pkg;
	localparam int NumCh = 2;
	localparam logic [3:0] GpiDeepSleep = 4'h0;
	localparam logic [3:0] GpiFaultDump = 4'h2;
	localparam logic [3:0] GpiCurPdn = 4'h3;
	localparam logic [3:0] GpiVoltPdn = 4'h4;
	localparam logic [3:0] GpiProtect = 4'h5;
	localparam logic [3:0] GpiClear = 4'h7;
	localparam logic [3:0] GpiLoad = 4'h8;
	localparam logic [3:0] GpiFuncGen = 4'h9;
	localparam logic [3:0] GpiMargin = 4'hA;
	localparam logic [3:0] GpiReset = 4'hB;
	localparam logic [3:0] GpiMemProg = 4'hC;
	localparam logic [3:0] GpiRegLock = 4'hD;
	localparam logic [3:0] GpoMemBusy = 4'h1;
	localparam logic [3:0] GpoCh1Busy = 4'h4;
	localparam logic [3:0] GpoCh0Busy = 4'h7;
	localparam logic [3:0] GpoWin1 = 4'h8;
	localparam logic [3:0] GpoWin0 = 4'hB;
	localparam logic [3:0] SelReset = 4'hF;
	typedef enum logic [2:0] {
		StBoot = 3'b001,
		StSample = 3'b010,
		StRun = 3'b100
	} gfm_state_t;
endpackage

// file: logic/gfm_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gfm_sync (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic din, // raw pin level
	output logic dout // filtered level
);
	logic s1_q, s2_q, s3_q, out_q;
	wire agree = (s2_q == s3_q);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			out_q <= 1'b1;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) out_q <= s3_q;
		end
	end
	assign dout = out_q;
endmodule

// file: logic/gpio_function_mapper.sv
// decoder for the multi-function pin, input actions and status output
`timescale 1ns/1ps
module gpio_function_mapper (
	input wire logic clk, // 20 MHz system clock
	input wire logic reset_n, // async reset, active low
	input wire logic pinIn, // pin level from pad
	output logic pinOut, // value driven onto pad
	output logic pinOe_n, // pad drive enable, low drives
	input wire logic pin_input_enable, // pin acts as input
	input wire logic pin_output_enable, // pin acts as output
	input wire logic [3:0] pin_input_function_sel, // input function code
	input wire logic [3:0] pin_output_status_sel, // output status code
	input wire logic [1:0] pin_channel_select, // channels for per-channel actions
	input wire logic [1:0] syncUpdateCfg, // per-channel synchronous update option
	input wire logic [1:0] voltage_out_powerdown_cfg0, // channel 0 pulldown choice
	input wire logic [1:0] voltage_out_powerdown_cfg1, // channel 1 pulldown choice
	input wire logic cfgFromNvm, // configuration loaded from nonvolatile memory
	input wire logic memory_busy_flag, // memory busy status
	input wire logic [1:0] channelBusy, // per-channel converter busy
	input wire logic channel0_window_result, // channel 0 window compare
	input wire logic channel1_window_result, // channel 1 window compare
	output logic deepSleep, // device in deep sleep
	output logic faultDumpPulse, // one-cycle fault dump request
	output logic [1:0] curPowerDown, // current output powered down per channel
	output logic [1:0] voltPowerDown, // voltage output powered down per channel
	output logic [3:0] voltPdnMode, // pulldown mode in use, ch1 high
	output logic protectPulse, // one-cycle protect request
	output logic output_clear_action, // one-cycle clear request
	output logic [1:0] load_converter_action, // one-cycle load per channel
	output logic [1:0] funcGenRun, // function generation running per channel
	output logic [1:0] marginLowPulse, // one-cycle margin-low trigger
	output logic [1:0] marginHighPulse, // one-cycle margin-high trigger
	output logic deviceResetPulse, // one-cycle device reset request
	output logic memProgAllowed, // nonvolatile programming allowed
	output logic regWriteBlocked, // register map writes blocked except unlock/reset fields
	output logic swTriggerDisabled // software trigger of mapped function disabled
);
	////////////////////////////////////////////////////////////////////////////////
	// pin conditioning and edge detection
	logic pinSync;
	logic pinPrev_q;
	gfm_sync uSync (
		.clk(clk),
		.reset_n(reset_n),
		.din(pinIn),
		.dout(pinSync)
	);
	gfm_pkg::gfm_state_t state_q, state_d;
	wire running = (state_q == gfm_pkg::StRun);
	wire sampling = (state_q == gfm_pkg::StSample);
	wire booting = (state_q == gfm_pkg::StBoot);
	wire inMode = pin_input_enable && !pin_output_enable;
	// a sampled low at boot counts as a falling edge, high as rising
	wire pinFell = pinPrev_q && !pinSync;
	wire pinRose = !pinPrev_q && pinSync;
	wire fallEv = inMode && ((running && pinFell) || (sampling && !pinSync));
	wire riseEv = inMode && ((running && pinRose) || (sampling && pinSync));
	// the reset code uses a full low pulse, so it ends on the rising edge after a seen fall
	logic lowSeen_q;
	wire [3:0] fsel = pin_input_function_sel;
	wire isReset = inMode && fsel == gfm_pkg::GpiReset && cfgFromNvm;
	wire [1:0] chSel = pin_channel_select;
	////////////////////////////////////////////////////////////////////////////////
	// boot sequence: wait for the synchroniser to settle, sample once
	logic [1:0] bootCnt_q;
	always_comb begin
		state_d = state_q;
		case (state_q)
			gfm_pkg::StBoot: if (&bootCnt_q) state_d = gfm_pkg::StSample;
			gfm_pkg::StSample: state_d = gfm_pkg::StRun;
			gfm_pkg::StRun: state_d = gfm_pkg::StRun;
			default: state_d = gfm_pkg::StBoot;
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= gfm_pkg::StBoot;
			bootCnt_q <= 2'b00;
			pinPrev_q <= 1'b1;
		end else begin
			state_q <= state_d;
			if (booting) bootCnt_q <= bootCnt_q + 2'b01;
			pinPrev_q <= pinSync;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// decode of actions
	wire selDeep = inMode && fsel == gfm_pkg::GpiDeepSleep;
	wire selCur = inMode && fsel == gfm_pkg::GpiCurPdn;
	wire selVolt = inMode && fsel == gfm_pkg::GpiVoltPdn;
	wire selFunc = inMode && fsel == gfm_pkg::GpiFuncGen;
	wire selMem = inMode && fsel == gfm_pkg::GpiMemProg;
	wire selLock = inMode && fsel == gfm_pkg::GpiRegLock;
	wire knownFn = (fsel == gfm_pkg::GpiDeepSleep) || (fsel == gfm_pkg::GpiFaultDump) || (fsel == gfm_pkg::GpiCurPdn)
		|| (fsel == gfm_pkg::GpiVoltPdn) || (fsel == gfm_pkg::GpiProtect) || (fsel == gfm_pkg::GpiClear)
		|| (fsel == gfm_pkg::GpiLoad) || (fsel == gfm_pkg::GpiFuncGen) || (fsel == gfm_pkg::GpiMargin)
		|| (fsel == gfm_pkg::GpiReset) || (fsel == gfm_pkg::GpiMemProg) || (fsel == gfm_pkg::GpiRegLock);
	wire swDis_d = inMode && knownFn && running;
	wire selFault = inMode && fsel == gfm_pkg::GpiFaultDump;
	wire selProt = inMode && fsel == gfm_pkg::GpiProtect;
	wire selClr = inMode && fsel == gfm_pkg::GpiClear;
	wire selLoad = inMode && fsel == gfm_pkg::GpiLoad;
	// these act on the fall only; their rise is deliberately ignored
	wire faultD = fallEv && selFault;
	wire protD = fallEv && selProt;
	wire clrD = fallEv && selClr;
	wire [1:0] loadD = (fallEv && selLoad) ? (chSel & syncUpdateCfg) : 2'b00;
	wire marginSel = inMode && fsel == gfm_pkg::GpiMargin;
	wire [1:0] mLowD = (fallEv && marginSel) ? chSel : 2'b00;
	wire [1:0] mHighD = (riseEv && marginSel) ? chSel : 2'b00;
	wire rstD = isReset && running && riseEv && lowSeen_q;
	wire [3:0] pdnModeD = {voltage_out_powerdown_cfg1, voltage_out_powerdown_cfg0};
	////////////////////////////////////////////////////////////////////////////////
	// per-channel power-down and function-run state
	logic [1:0] curPdn_q, voltPdn_q, funcRun_q;
	genvar ch;
	generate
		for (ch = 0; ch < gfm_pkg::NumCh; ch++) begin : gChan
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					curPdn_q[ch] <= 1'b0;
					voltPdn_q[ch] <= 1'b0;
					funcRun_q[ch] <= 1'b0;
				end else begin
					if (selCur && chSel[ch] && fallEv) curPdn_q[ch] <= 1'b1;
					else if (selCur && chSel[ch] && riseEv) curPdn_q[ch] <= 1'b0;
					if (selVolt && chSel[ch] && fallEv) voltPdn_q[ch] <= 1'b1;
					else if (selVolt && chSel[ch] && riseEv) voltPdn_q[ch] <= 1'b0;
					if (selFunc && chSel[ch] && fallEv) funcRun_q[ch] <= 1'b0;
					else if (selFunc && chSel[ch] && riseEv) funcRun_q[ch] <= 1'b1;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////////
	// global levels and pulses
	logic deep_q, memOk_q, lock_q, swDis_q, lowSeen_d;
	logic fault_q, prot_q, clr_q, rst_q;
	logic [1:0] load_q, mLow_q, mHigh_q;
	logic [3:0] pdnMode_q;
	assign lowSeen_d = isReset ? (fallEv ? 1'b1 : (riseEv ? 1'b0 : lowSeen_q)) : 1'b0;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			deep_q <= 1'b0;
			memOk_q <= 1'b0;
			swDis_q <= 1'b0;
			lowSeen_q <= 1'b0;
		end else begin
			if (selDeep && fallEv) deep_q <= 1'b1;
			else if (selDeep && riseEv) deep_q <= 1'b0;
			if (selMem && fallEv) memOk_q <= 1'b1;
			else if (selMem && riseEv) memOk_q <= 1'b0;
			swDis_q <= swDis_d;
			lowSeen_q <= lowSeen_d;
		end
	end
	// lock level kept apart: the field exceptions are enforced where writes are decoded
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_q <= 1'b0;
		end else begin
			if (selLock && fallEv) lock_q <= 1'b0;
			else if (selLock && riseEv) lock_q <= 1'b1;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_q <= 1'b0;
			prot_q <= 1'b0;
			clr_q <= 1'b0;
			rst_q <= 1'b0;
			load_q <= 2'b00;
			mLow_q <= 2'b00;
			mHigh_q <= 2'b00;
			pdnMode_q <= 4'h0;
		end else begin
			fault_q <= faultD;
			prot_q <= protD;
			clr_q <= clrD;
			rst_q <= rstD;
			load_q <= loadD;
			mLow_q <= mLowD;
			mHigh_q <= mHighD;
			pdnMode_q <= pdnModeD;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// status output; nothing mapped until configured
	logic out_q, oe_n_q;
	wire outMode = pin_output_enable && !pin_input_enable;
	// one match per listed code; an unlisted code leaves every match low, so the pad reads low
	wire [3:0] osel = pin_output_status_sel;
	wire hitMem = (osel == gfm_pkg::GpoMemBusy);
	wire hitBusy1 = (osel == gfm_pkg::GpoCh1Busy);
	wire hitBusy0 = (osel == gfm_pkg::GpoCh0Busy);
	wire hitWin1 = (osel == gfm_pkg::GpoWin1);
	wire hitWin0 = (osel == gfm_pkg::GpoWin0);
	wire statusBit = (hitMem && memory_busy_flag) || (hitBusy1 && channelBusy[1]) || (hitBusy0 && channelBusy[0])
		|| (hitWin1 && channel1_window_result) || (hitWin0 && channel0_window_result);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			out_q <= outMode ? statusBit : 1'b0;
			oe_n_q <= !outMode;
		end
	end
	assign pinOut = out_q;
	assign pinOe_n = oe_n_q;
	assign deepSleep = deep_q;
	assign faultDumpPulse = fault_q;
	assign curPowerDown = curPdn_q;
	assign voltPowerDown = voltPdn_q;
	assign voltPdnMode = pdnMode_q;
	assign protectPulse = prot_q;
	assign output_clear_action = clr_q;
	assign load_converter_action = load_q;
	assign funcGenRun = funcRun_q;
	assign marginLowPulse = mLow_q;
	assign marginHighPulse = mHigh_q;
	assign deviceResetPulse = rst_q;
	assign memProgAllowed = memOk_q;
	assign regWriteBlocked = lock_q;
	assign swTriggerDisabled = swDis_q;
endmodule

// file: sim/gfm_props.sv
// concurrent checks on the multi-function pin mapper ports
`timescale 1ns/1ps
module gfm_props (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic pinOut, // pad drive value
	input wire logic pinOe_n, // pad drive enable, low drives
	input wire logic pin_input_enable, // input mode
	input wire logic pin_output_enable, // output mode
	input wire logic [3:0] pin_input_function_sel, // input code
	input wire logic [3:0] pin_output_status_sel, // output code
	input wire logic [1:0] pin_channel_select, // channel select
	input wire logic [1:0] syncUpdateCfg, // sync update option
	input wire logic cfgFromNvm, // setting from memory
	input wire logic channel0_window_result, // window result
	input wire logic deepSleep, // sleep level
	input wire logic faultDumpPulse, // dump pulse
	input wire logic [1:0] voltPowerDown, // voltage power-down
	input wire logic [1:0] load_converter_action, // load pulses
	input wire logic deviceResetPulse, // reset pulse
	input wire logic regWriteBlocked // write lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////////////
	single_reset_pulse_a: assert property (deviceResetPulse |=> !deviceResetPulse) else $error("reset pulse too long");
	single_dump_pulse_a: assert property (faultDumpPulse |=> !faultDumpPulse) else $error("dump pulse too long");
	drive_mode_a: assert property (!pinOe_n |-> $past(pin_output_enable && !pin_input_enable)) else $error("pad driven outside output mode");
	idle_low_a: assert property (pinOe_n |-> !pinOut) else $error("value without drive");
	window_out_a: assert property ($past(reset_n) && $past(pin_output_enable && !pin_input_enable
		&& pin_output_status_sel == gfm_pkg::GpoWin0) |-> pinOut == $past(channel0_window_result)) else $error("window flag not on pad");
	load_select_a: assert property (load_converter_action != 2'h0 |-> $past(pin_input_function_sel) == gfm_pkg::GpiLoad
		&& (load_converter_action & ~$past(pin_channel_select & syncUpdateCfg)) == 2'h0) else $error("load on wrong channel");
	reset_nvm_a: assert property (deviceResetPulse |-> $past(cfgFromNvm) && $past(pin_input_function_sel) == gfm_pkg::GpiReset)
		else $error("reset without stored setting");
	sleep_cause_a: assert property ($changed(deepSleep) |-> $past(pin_input_function_sel) == gfm_pkg::GpiDeepSleep) else $error("sleep change");
	lock_cause_a: assert property ($changed(regWriteBlocked) |-> $past(pin_input_function_sel) == gfm_pkg::GpiRegLock
		&& $past(pin_input_enable)) else $error("lock change");
	volt_cause_a: assert property ($rose(voltPowerDown[1]) |-> $past(pin_channel_select[1])
		&& $past(pin_input_function_sel) == gfm_pkg::GpiVoltPdn) else $error("power-down cause");
endmodule
bind gpio_function_mapper gfm_props i_props (.clk, .reset_n, .pinOut, .pinOe_n, .pin_input_enable, .pin_output_enable,
	.pin_input_function_sel, .pin_output_status_sel, .pin_channel_select, .syncUpdateCfg, .cfgFromNvm,
	.channel0_window_result, .deepSleep, .faultDumpPulse, .voltPowerDown, .load_converter_action, .deviceResetPulse,
	.regWriteBlocked);

// file: sim/gfm_pin_partner.sv
// board side of the multi-function pin: controller drive and pull-up
`timescale 1ns/1ps
module gfm_pin_partner (
	input wire logic drvEn, // controller drives the pin
	input wire logic drvLvl, // level the controller drives
	input wire logic pinOut, // device drive value
	input wire logic pinOe_n, // device drive enable, low drives
	output logic pad // resolved pin level
);
	// pull-up keeps a released pin at a defined level, never floating
	assign pad = !pinOe_n ? pinOut : (drvEn ? drvLvl : 1'b1);
endmodule

// file: sim/gpio_function_mapper_test.sv
// self-checking bench for the multi-function pin mapper
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module gpio_function_mapper_test;
	logic clk = 0, reset_n = 0, pinIn, pinOut, pinOe_n, pin_input_enable = 0, pin_output_enable = 0, cfgFromNvm = 0;
	logic memory_busy_flag = 0, channel0_window_result = 0, channel1_window_result = 0, drvEn = 1, drvLvl = 1, rstSeen = 0;
	logic [3:0] pin_input_function_sel = 0, pin_output_status_sel = 0, voltPdnMode;
	logic [1:0] pin_channel_select = 0, syncUpdateCfg = 0, voltage_out_powerdown_cfg0 = 0, voltage_out_powerdown_cfg1 = 0;
	logic [1:0] channelBusy = 0, curPowerDown, voltPowerDown, load_converter_action, funcGenRun, loadSeen = 0;
	logic [1:0] marginLowPulse, marginHighPulse;
	logic deepSleep, faultDumpPulse, protectPulse, output_clear_action, deviceResetPulse, memProgAllowed;
	logic regWriteBlocked, swTriggerDisabled;
	logic [6:0] pulseSeen = 0;
	logic [11:0] fallV, riseV;
	logic seenClr = 0;
	wire [4:0] lvls = {curPowerDown, funcGenRun, memProgAllowed};
	int mismatches = 0, samples_checked = 0;
	// {status code, memory busy, busy1, busy0, window1, window0, expected pad}
	logic [9:0] rows [10] = '{10'h061, 10'h05E, 10'h111, 10'h12E, 10'h1C9, 10'h1F6, 10'h205, 10'h23A, 10'h2C3, 10'h0FE};
	gpio_function_mapper i_dut (.clk, .reset_n, .pinIn, .pinOut, .pinOe_n, .pin_input_enable, .pin_output_enable,
		.pin_input_function_sel, .pin_output_status_sel, .pin_channel_select, .syncUpdateCfg, .voltage_out_powerdown_cfg0,
		.voltage_out_powerdown_cfg1, .cfgFromNvm, .memory_busy_flag, .channelBusy, .channel0_window_result,
		.channel1_window_result, .deepSleep, .faultDumpPulse, .curPowerDown, .voltPowerDown, .voltPdnMode, .protectPulse,
		.output_clear_action, .load_converter_action, .funcGenRun, .marginLowPulse, .marginHighPulse, .deviceResetPulse,
		.memProgAllowed, .regWriteBlocked, .swTriggerDisabled);
	gfm_pin_partner i_partner (.drvEn, .drvLvl, .pinOut, .pinOe_n, .pad(pinIn));
	initial forever #25 clk = ~clk;
	// pulses last one cycle, so they are gathered between edges
	always @(posedge clk) begin
		loadSeen <= seenClr ? 2'b00 : (loadSeen | load_converter_action);
		rstSeen <= !seenClr && (rstSeen || deviceResetPulse);
		pulseSeen <= seenClr ? 7'h00 : (pulseSeen | {faultDumpPulse, protectPulse, output_clear_action, marginLowPulse,
			marginHighPulse});
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic done(input string s);
		$display("%s test done", s);
	endtask
	task automatic setIn(input logic [3:0] c);
		@(negedge clk);
		pin_input_function_sel = c;
		pin_input_enable = 1;
		repeat (2) @(negedge clk);
	endtask
	// filter and register latency settle well inside eight cycles
	task automatic padEdge(input logic lvl);
		@(negedge clk);
		seenClr = 1;
		drvLvl = lvl;
		@(negedge clk);
		seenClr = 0;
		repeat (7) @(negedge clk);
	endtask
	// one fall then one rise under a code, pulses, per-channel levels and memory-ok caught after each
	task automatic twoEdges(input logic [3:0] c, output logic [11:0] atFall, output logic [11:0] atRise);
		setIn(c);
		padEdge(0);
		atFall = {pulseSeen, lvls};
		padEdge(1);
		atRise = {pulseSeen, lvls};
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (8) @(negedge clk);
		`CHK("pinOe_n", 1'b1, pinOe_n)
		reset_n = 1;
		repeat (10) @(negedge clk);
		foreach (rows[i]) begin
			{pin_output_status_sel, memory_busy_flag, channelBusy, channel1_window_result, channel0_window_result} = rows[i][9:1];
			pin_output_enable = 1;
			drvEn = 0;
			repeat (3) @(negedge clk);
			`CHK("pad", rows[i][0], pinIn)
			`CHK("pinOe_n", 1'b0, pinOe_n)
		end
		pin_output_enable = 0;
		drvEn = 1;
		done("status");
		`CHK("swTriggerDisabled", 1'b0, swTriggerDisabled)
		setIn(4'h1);
		`CHK("swTriggerDisabled", 1'b0, swTriggerDisabled)
		setIn(gfm_pkg::GpiDeepSleep);
		`CHK("swTriggerDisabled", 1'b1, swTriggerDisabled)
		pin_input_enable = 0;
		padEdge(0);
		`CHK("deepSleep", 1'b0, deepSleep)
		padEdge(1);
		setIn(gfm_pkg::GpiDeepSleep);
		padEdge(0);
		`CHK("deepSleep", 1'b1, deepSleep)
		padEdge(1);
		`CHK("deepSleep", 1'b0, deepSleep)
		done("sleep");
		pin_channel_select = 2'h2;
		voltage_out_powerdown_cfg0 = 2'h1;
		voltage_out_powerdown_cfg1 = 2'h3;
		setIn(gfm_pkg::GpiVoltPdn);
		padEdge(0);
		`CHK("voltPowerDown", 2'h2, voltPowerDown)
		`CHK("voltPdnMode", 4'hD, voltPdnMode)
		padEdge(1);
		`CHK("voltPowerDown", 2'h0, voltPowerDown)
		done("power-down");
		pin_channel_select = 2'h3;
		syncUpdateCfg = 2'h1;
		setIn(gfm_pkg::GpiLoad);
		padEdge(0);
		`CHK("load", 2'h1, loadSeen)
		padEdge(1);
		`CHK("load", 2'h0, loadSeen)
		done("load");
		// vector is {dump, protect, clear, margin low[1:0], margin high[1:0], current pdn[1:0], func run[1:0], mem ok}
		pin_channel_select = 2'h1;
		twoEdges(gfm_pkg::GpiFaultDump, fallV, riseV);
		`CHK("fault", 12'h800, fallV)
		`CHK("fault", 12'h000, riseV)
		twoEdges(gfm_pkg::GpiProtect, fallV, riseV);
		`CHK("protect", 12'h400, fallV)
		`CHK("protect", 12'h000, riseV)
		twoEdges(gfm_pkg::GpiClear, fallV, riseV);
		`CHK("clear", 12'h200, fallV)
		`CHK("clear", 12'h000, riseV)
		twoEdges(gfm_pkg::GpiMargin, fallV, riseV);
		`CHK("margin", 12'h080, fallV)
		`CHK("margin", 12'h020, riseV)
		twoEdges(gfm_pkg::GpiCurPdn, fallV, riseV);
		`CHK("current", 12'h008, fallV)
		`CHK("current", 12'h000, riseV)
		twoEdges(gfm_pkg::GpiMemProg, fallV, riseV);
		`CHK("memory", 12'h001, fallV)
		`CHK("memory", 12'h000, riseV)
		twoEdges(gfm_pkg::GpiFuncGen, fallV, riseV);
		`CHK("funcgen", 12'h000, fallV)
		`CHK("funcgen", 12'h002, riseV)
		padEdge(0);
		`CHK("funcGenRun", 2'h0, funcGenRun)
		padEdge(1);
		done("functions");
		setIn(gfm_pkg::GpiReset);
		padEdge(0);
		padEdge(1);
		`CHK("reset", 1'b0, rstSeen)
		cfgFromNvm = 1;
		padEdge(0);
		`CHK("reset", 1'b0, rstSeen)
		padEdge(1);
		`CHK("reset", 1'b1, rstSeen)
		done("reset");
		setIn(gfm_pkg::GpiRegLock);
		padEdge(0);
		`CHK("regWriteBlocked", 1'b0, regWriteBlocked)
		padEdge(1);
		`CHK("regWriteBlocked", 1'b1, regWriteBlocked)
		padEdge(0);
		`CHK("regWriteBlocked", 1'b0, regWriteBlocked)
		reset_n = 0;
		@(negedge clk);
		`CHK("regWriteBlocked", 1'b0, regWriteBlocked)
		`CHK("pinOe_n", 1'b1, pinOe_n)
		drvLvl = 1;
		reset_n = 1;
		repeat (12) @(negedge clk);
		`CHK("regWriteBlocked", 1'b1, regWriteBlocked)
		done("lock");
		finish_test;
	end
endmodule
